// [hw/eeprom_ecc_defs.vh]
`ifndef EEPROM_ECC_DEFS_VH
`define EEPROM_ECC_DEFS_VH

// Array geometry
`define ARRAY_ADDR_W      14
`define GROUP_BYTES       4
`define GROUP_SEL_W       2
`define GROUP_DATA_W      32
`define GROUP_CHECK_W     6
`define GROUP_CODE_W      38

// Delivery contents
`define ERASED_BYTE       8'hff
`define ID_PAGE_BYTES     64
`define ID_PAGE_ADDR_W    6
`define ID_CODE_BYTES     3
`define ID_CODE_DEFAULT   24'h5a_a5_3c

// Status bit positions and delivery values
`define SR_LOCK_POS       7
`define SR_BP_HIGH_POS    3
`define SR_BP_LOW_POS     2
`define SR_DELIVERY_BIT   1'b0

`endif

// [hw/eeprom_group_ecc.v]
`timescale 1ns/1ps
`include "eeprom_ecc_defs.vh"

// Operation
// - The array is split into aligned four-byte groups, each holding one correction code.
// - A read of a group with exactly one wrong stored bit returns the corrected value.
// - A single byte may be written without the other bytes of its group being supplied.
// - Writing any byte rewrites the other three with their present contents and a new code.
// - Coding adds no command, status, wait state or timing change seen by the bus side.
// - In the delivery state every array byte holds ff.
// - In the delivery state the write-lock bit and both area-protect bits are zero.
// - In the delivery state the identity page holds the identity code then 61 bytes of ff.
module eeprom_group_ecc #(
  parameter ADDR_W  = `ARRAY_ADDR_W,
  parameter ID_CODE = `ID_CODE_DEFAULT  // Arbitrary value
) (
  // Clock and reset
  input  wire              clk,
  input  wire              rst,
  // Array access
  input  wire              rd_en,
  input  wire              wr_en,
  input  wire [ADDR_W-1:0] addr,
  input  wire [7:0]        wr_byte,
  output reg  [7:0]        rd_byte_q,
  output reg               rd_valid_q,
  // Stored-bit disturbance
  input  wire              flip_en,
  input  wire [ADDR_W-3:0] flip_group,
  input  wire [5:0]        flip_bit,
  // Status bits
  input  wire              sr_wr,
  input  wire [7:0]        sr_wdata,
  output reg               status_write_lock_bit_q,
  output reg               protect_area_bit_high_q,
  output reg               protect_area_bit_low_q,
  // Identification page
  input  wire              id_rd,
  input  wire              id_wr,
  input  wire [5:0]        id_addr,
  input  wire [7:0]        id_wdata,
  output reg  [7:0]        id_rbyte_q,
  output reg               id_valid_q
);

  localparam GROUPS  = 1 << (ADDR_W - `GROUP_SEL_W);
  localparam GIDX_W  = ADDR_W - `GROUP_SEL_W;
  localparam DATA_W  = `GROUP_DATA_W;
  localparam CHECK_W = `GROUP_CHECK_W;

  // Group storage, one code per group
  reg [DATA_W-1:0]  data_q  [0:GROUPS-1];
  reg [CHECK_W-1:0] check_q [0:GROUPS-1];
  reg [7:0]         id_q    [0:`ID_PAGE_BYTES-1];

  wire [GIDX_W-1:0] grp  = addr[ADDR_W-1:`GROUP_SEL_W];
  wire [1:0]        bsel = addr[`GROUP_SEL_W-1:0];

  wire [DATA_W-1:0]  corr_data;
  wire [DATA_W-1:0]  merged_data;
  wire [CHECK_W-1:0] merged_check;

  group_ecc_codec #(
    .DATA_W  (DATA_W),
    .CHECK_W (CHECK_W)
  ) u_codec (
    .stored_data  (data_q[grp]),
    .stored_check (check_q[grp]),
    .byte_sel     (bsel),
    .byte_val     (wr_byte),
    .corr_data    (corr_data),
    .merged_data  (merged_data),
    .merged_check (merged_check)
  );

  // Code of an all-ones group, fixed at elaboration
  function [CHECK_W-1:0] erased_check;
    input integer dummy;
    integer p;
    integer c;
    reg [CHECK_W-1:0] acc;
    begin
      acc = {CHECK_W{1'b0}};
      c = 0;
      for (p = 1; p < (1 << CHECK_W); p = p + 1) begin
        if ((p & (p - 1)) != 0) begin
          if (c < DATA_W) begin
            acc = acc ^ p[CHECK_W-1:0];
          end
          c = c + 1;
        end
      end
      erased_check = acc + {CHECK_W{1'b0}} * dummy[0];
    end
  endfunction

  localparam [CHECK_W-1:0] ERASED_CHECK = erased_check(0);

  // Disturbance mask over the stored codeword; data bits low, check bits high
  wire [`GROUP_CODE_W-1:0] flip_mask = {{(`GROUP_CODE_W-1){1'b0}}, 1'b1} << flip_bit;
  wire                     flip_live = flip_en && !(wr_en && flip_group == grp);

  integer k;
  integer n;

  // Array: reset models the delivery contents
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (k = 0; k < GROUPS; k = k + 1) begin
        data_q[k]  <= {`GROUP_BYTES{`ERASED_BYTE}};
        check_q[k] <= ERASED_CHECK;
      end
    end else begin
      if (wr_en) begin
        // Whole group rewritten from one byte, in the same cycle as the request
        data_q[grp]  <= merged_data;
        check_q[grp] <= merged_check;
      end
      if (flip_live) begin
        data_q[flip_group]  <= data_q[flip_group] ^ flip_mask[DATA_W-1:0];
        check_q[flip_group] <= check_q[flip_group] ^ flip_mask[`GROUP_CODE_W-1:DATA_W];
      end
    end
  end

  // Read path: fixed one-cycle latency, no error indication exists
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_byte_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_en;
      if (rd_en) begin
        rd_byte_q <= corr_data[bsel*8 +: 8];
      end
    end
  end

  // Status bits; only these three are kept here
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      status_write_lock_bit_q <= `SR_DELIVERY_BIT;
      protect_area_bit_high_q <= `SR_DELIVERY_BIT;
      protect_area_bit_low_q  <= `SR_DELIVERY_BIT;
    end else if (sr_wr) begin
      status_write_lock_bit_q <= sr_wdata[`SR_LOCK_POS];
      protect_area_bit_high_q <= sr_wdata[`SR_BP_HIGH_POS];
      protect_area_bit_low_q  <= sr_wdata[`SR_BP_LOW_POS];
    end
  end

  // Identification page, not covered by the group code
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (n = 0; n < `ID_PAGE_BYTES; n = n + 1) begin
        id_q[n] <= `ERASED_BYTE;
      end
      id_q[0] <= ID_CODE[23:16];
      id_q[1] <= ID_CODE[15:8];
      id_q[2] <= ID_CODE[7:0];
    end else if (id_wr) begin
      id_q[id_addr] <= id_wdata;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      id_rbyte_q <= 8'h00;
      id_valid_q <= 1'b0;
    end else begin
      id_valid_q <= id_rd;
      if (id_rd) begin
        id_rbyte_q <= id_q[id_addr];
      end
    end
  end

endmodule // eeprom_group_ecc

// [hw/group_ecc_codec.v]
`timescale 1ns/1ps
`include "eeprom_ecc_defs.vh"

module group_ecc_codec #(
  parameter DATA_W  = `GROUP_DATA_W,
  parameter CHECK_W = `GROUP_CHECK_W
) (
  // Stored group
  input  wire [DATA_W-1:0]  stored_data,
  input  wire [CHECK_W-1:0] stored_check,
  // Byte to merge
  input  wire [1:0]         byte_sel,
  input  wire [7:0]         byte_val,
  // Results
  output wire [DATA_W-1:0]  corr_data,
  output wire [DATA_W-1:0]  merged_data,
  output wire [CHECK_W-1:0] merged_check
);

  // Codeword position of data bit idx: the idx-th non power of two position
  function [CHECK_W-1:0] dpos;
    input integer idx;
    integer p;
    integer c;
    begin
      dpos = {CHECK_W{1'b0}};
      c = 0;
      for (p = 1; p < (1 << CHECK_W); p = p + 1) begin
        if ((p & (p - 1)) != 0) begin
          if (c == idx) begin
            dpos = p[CHECK_W-1:0];
          end
          c = c + 1;
        end
      end
    end
  endfunction

  function [CHECK_W-1:0] encode;
    input [DATA_W-1:0] d;
    integer i;
    reg [CHECK_W-1:0] pos;
    begin
      encode = {CHECK_W{1'b0}};
      for (i = 0; i < DATA_W; i = i + 1) begin
        pos = dpos(i);
        encode = encode ^ (pos & {CHECK_W{d[i]}});
      end
    end
  endfunction

  wire [CHECK_W-1:0] syndrome = stored_check ^ encode(stored_data);

  // Single bit error in data flips that bit; check-bit or clean: pass through
  genvar g;
  generate
    for (g = 0; g < DATA_W; g = g + 1) begin : fix
      assign corr_data[g] = stored_data[g] ^ (syndrome == dpos(g));
    end
  endgenerate

  // Other bytes keep their corrected contents
  generate
    for (g = 0; g < `GROUP_BYTES; g = g + 1) begin : mrg
      assign merged_data[g*8 +: 8] = (byte_sel == g) ? byte_val : corr_data[g*8 +: 8];
    end
  endgenerate

  assign merged_check = encode(merged_data);

endmodule // group_ecc_codec

// [tb/eeprom_group_ecc_chk.sv]
`timescale 1ns/1ps
module eeprom_group_ecc_chk #(
  parameter ADDR_W = 14
) (
  // Clock and reset
  input wire              clk,
  input wire              rst,
  // Requests
  input wire              rd_en,
  input wire              wr_en,
  input wire              sr_wr,
  input wire              id_rd,
  input wire [ADDR_W-1:0] addr,
  input wire [7:0]        wr_byte,
  input wire [7:0]        sr_wdata,
  // Answers
  input wire              rd_valid_q,
  input wire              id_valid_q,
  input wire [7:0]        rd_byte_q,
  input wire              status_write_lock_bit_q,
  input wire              protect_area_bit_high_q,
  input wire              protect_area_bit_low_q
);
  wire [2:0] sr = {status_write_lock_bit_q, protect_area_bit_high_q, protect_area_bit_low_q};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rd_answer: assert property (rd_en |=> rd_valid_q)
    else $error("read not answered");
  a_rd_quiet: assert property (!rd_en |=> !rd_valid_q && $stable(rd_byte_q))
    else $error("read output moved");
  a_id_answer: assert property (id_rd |=> id_valid_q)
    else $error("id read not answered");
  a_id_quiet: assert property (!id_rd |=> !id_valid_q)
    else $error("spurious id valid");
  a_sr_load: assert property (sr_wr |=> sr == {$past(sr_wdata[7]), $past(sr_wdata[3:2])})
    else $error("status load wrong");
  a_sr_hold: assert property (!sr_wr |=> $stable(sr))
    else $error("status bits moved");
  a_write_read_back: assert property
    (wr_en ##1 (rd_en && addr == $past(addr)) |=> rd_byte_q == $past(wr_byte, 2))
    else $error("written byte not read back");
  a_reset_state: assert property (disable iff (1'b0) rst |-> sr == 3'h0 && !rd_valid_q)
    else $error("delivery state wrong");
endmodule // eeprom_group_ecc_chk
bind eeprom_group_ecc eeprom_group_ecc_chk #(.ADDR_W(ADDR_W)) eeprom_group_ecc_chk_inst (.clk,
  .rst, .rd_en, .wr_en, .sr_wr, .id_rd, .rd_valid_q, .id_valid_q, .addr, .wr_byte, .sr_wdata,
  .rd_byte_q, .status_write_lock_bit_q, .protect_area_bit_high_q, .protect_area_bit_low_q);

// [tb/spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model #(
  parameter ADDR_W = 6
) (
  // Clock
  input  wire              clk,
  // Array requests
  output reg               rd_en,
  output reg               wr_en,
  output reg  [ADDR_W-1:0] addr,
  output reg  [7:0]        wr_byte,
  // Stored-bit disturbance
  output reg               flip_en,
  output reg  [ADDR_W-3:0] flip_group,
  output reg  [5:0]        flip_bit,
  // Status and id page
  output reg               sr_wr,
  output reg  [7:0]        sr_wdata,
  output reg               id_rd,
  output reg               id_wr,
  output reg  [5:0]        id_addr,
  output reg  [7:0]        id_wdata
);
  initial {rd_en, wr_en, flip_en, sr_wr, id_rd, id_wr, addr, wr_byte, sr_wdata} = '0;
  initial {flip_group, flip_bit, id_addr, id_wdata} = '0;
  // One call a cycle, and the requests it sets may coincide; only the target byte is sent, never the whole group
  // With w and i both set the byte goes to the id page, not the array
  task automatic op(input bit r, w, f, s, i, input logic [ADDR_W-1:0] a,
                    input logic [7:0] d, input logic [5:0] b);
    @(posedge clk);
    #1;
    {rd_en, wr_en, flip_en, sr_wr} = {r, w & ~i, f, s};
    {id_rd, id_wr} = {i & ~w, w & i};
    addr = a;
    wr_byte = w ? d : ~wr_byte;
    sr_wdata = d;
    id_wdata = d;
    flip_group = a[ADDR_W-1:2];
    flip_bit = b;
    id_addr = b;
  endtask
endmodule // spi_host_model

// [tb/test_eeprom_group_ecc.sv]
`timescale 1ns/1ps
`define CMP(nm, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", nm, e, s); end end
module test_eeprom_group_ecc;
  localparam ADDR_W = 6;
  localparam [23:0] ID = 24'h31_c7_0e; // Arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b0;
  int n_mismatch, checks;
  logic [7:0] exp_q[$];
  logic [7:0] m[64];
  logic [7:0] e;
  wire rd_en, wr_en, flip_en, sr_wr, id_rd, id_wr, rd_valid_q, id_valid_q;
  wire status_write_lock_bit_q, protect_area_bit_high_q, protect_area_bit_low_q;
  wire [ADDR_W-1:0] addr;
  wire [ADDR_W-3:0] flip_group;
  wire [7:0] wr_byte, sr_wdata, rd_byte_q, id_rbyte_q, id_wdata;
  wire [5:0] flip_bit, id_addr;
  wire [2:0] sr = {status_write_lock_bit_q, protect_area_bit_high_q, protect_area_bit_low_q};
  always #5 clk = ~clk;
  spi_host_model #(.ADDR_W(ADDR_W)) spi_host_model_inst (.clk, .rd_en, .wr_en, .flip_en, .sr_wr,
    .id_rd, .id_wr, .addr, .wr_byte, .sr_wdata, .id_wdata, .flip_group, .flip_bit, .id_addr);
  eeprom_group_ecc #(.ADDR_W(ADDR_W), .ID_CODE(ID)) eeprom_group_ecc_inst (.clk, .rst, .rd_en,
    .wr_en, .addr, .wr_byte, .rd_byte_q, .rd_valid_q, .flip_en, .flip_group, .flip_bit, .sr_wr,
    .sr_wdata, .status_write_lock_bit_q, .protect_area_bit_high_q, .protect_area_bit_low_q,
    .id_rd, .id_wr, .id_addr, .id_wdata, .id_rbyte_q, .id_valid_q);
  // Id page writes (w and i together) give no answer
  task automatic go(bit r, w, f, s, i, logic [5:0] a, logic [7:0] d, logic [7:0] x);
    spi_host_model_inst.op(r, w, f, s, i, a, d, f ? d[5:0] : a);
    if (r | (i & ~w)) exp_q.push_back(x);
  endtask
  // Every array byte and the whole id page against the delivery state
  task automatic sweep;
    logic [7:0] x;
    for (int i = 0; i < 64; i++) go(1, 0, 0, 0, 0, i[5:0], 0, 8'hff);
    for (int i = 0; i < 64; i++) begin
      x = (i < 3) ? ID[23-8*i -: 8] : 8'hff;
      go(0, 0, 0, 0, 1, i[5:0], 0, x);
    end
  endtask
  task close_out;
    if (n_mismatch == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Sampled mid-cycle so the edge's updates have landed
  always @(negedge clk) begin
    if (rd_valid_q === 1'b1 || id_valid_q === 1'b1) begin
      e = exp_q.pop_front();
      `CMP("read byte", e, rd_valid_q ? rd_byte_q : id_rbyte_q)
    end
  end
  initial begin : main
    logic [5:0] a, b;
    logic [7:0] d;
    void'($urandom(32'h8e15));
    foreach (m[i]) m[i] = 8'hff;
    // Raised after time zero so the asynchronous reset sees a real edge
    #1 rst = 1'b1;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    `CMP("status", 3'h0, sr)
    sweep();
    go(0, 0, 0, 1, 0, 0, 8'h8c, 0);
    go(0, 0, 0, 1, 0, 0, 8'h73, 0);
    `CMP("status", 3'h7, sr)
    // Id code overwritten here must come back with the delivery state
    go(0, 1, 0, 0, 1, 0, ~ID[23:16], 0);
    go(0, 0, 0, 0, 1, 0, 0, ~ID[23:16]);
    // Each group is written before its flip, so a flip never stacks on an older one
    repeat (40) begin
      a = $urandom_range(63);
      d = $urandom;
      go(1, 1, 0, 0, 0, a, d, m[a]);
      m[a] = d;
      go(1, 0, 0, 0, 0, a, 0, d);
      go(0, 0, 1, 0, 0, a, $urandom_range(37), 0);
      for (int k = 1; k < 5; k++) begin
        b = {a[5:2], a[1:0] + k[1:0]};
        go(1, 0, 0, 0, 0, b, 0, m[b]);
      end
    end
    go(0, 0, 0, 1, 0, 0, 8'h8c, 0);
    go(0, 0, 0, 0, 0, 0, 0, 0);
    `CMP("status", 3'h7, sr)
    // Mid-run reset with the bus idle and no answer pending
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    `CMP("status", 3'h0, sr)
    sweep();
    go(0, 0, 0, 0, 0, 0, 0, 0);
    repeat (3) @(posedge clk);
    `CMP("pending", 0, exp_q.size())
    close_out();
  end
  initial begin
    #50us;
    n_mismatch++;
    close_out();
  end
endmodule // test_eeprom_group_ecc
